// ### sse_checker.sv
// Port checker for the serial engine and bus emulation block
`default_nettype none
module sse_checker (
   // Clock, reset and read-back stream
   input wire logic       sys_clk_i,
   input wire logic       rstn_i,
   input wire logic [7:0] mode_o,
   input wire logic       rsp_valid_o,
   input wire logic       rsp_ready_i,
   input wire logic [7:0] rsp_data_o,
   // Serial and general lines
   input wire logic       serial_clock_out_o,
   input wire logic       serial_select_o,
   input wire logic [7:0] gp_line_oe_o,
   // Emulated bus
   input wire logic [7:0] muxbus_oe_o,
   input wire logic [7:0] upper_addr_o,
   input wire logic       addr_latch_o,
   input wire logic       bus_cs_n_o,
   input wire logic       bus_rd_n_o,
   input wire logic       bus_wr_n_o,
   input wire logic       access_ready_in_i
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rstn_i);
   property p_ser_idle;
      mode_o != 8'h02 |-> serial_select_o && gp_line_oe_o == 8'h00;
   endproperty
   a_ser_idle: assert property (p_ser_idle) else $error("serial active");
   property p_bus_idle;
      mode_o != 8'h08 |-> muxbus_oe_o == 8'h00 && upper_addr_o == 8'h00;
   endproperty
   a_bus_idle: assert property (p_bus_idle) else $error("bus active");
   property p_ale;
      addr_latch_o |-> muxbus_oe_o == 8'hFF && bus_cs_n_o ##1 !addr_latch_o;
   endproperty
   a_ale: assert property (p_ale) else $error("latch pulse bad");
   property p_rd_rel;
      !bus_rd_n_o |-> muxbus_oe_o == 8'h00 && !bus_cs_n_o;
   endproperty
   a_rd_rel: assert property (p_rd_rel) else $error("read drives bus");
   property p_wr_drv;
      !bus_wr_n_o |-> muxbus_oe_o == 8'hFF && !bus_cs_n_o;
   endproperty
   a_wr_drv: assert property (p_wr_drv) else $error("write undriven");
   property p_cs_min;
      $fell(bus_cs_n_o) |-> !bus_cs_n_o[*5];
   endproperty
   a_cs_min: assert property (p_cs_min) else $error("select short");
   property p_stretch;
      !access_ready_in_i[*4] ##0 !bus_cs_n_o |=> !bus_cs_n_o;
   endproperty
   a_stretch: assert property (p_stretch) else $error("no stretch");
   property p_upper;
      !bus_cs_n_o |-> $stable(upper_addr_o);
   endproperty
   a_upper: assert property (p_upper) else $error("upper moved");
   property p_rsp_hold;
      rsp_valid_o && !rsp_ready_i |=> rsp_valid_o && $stable(rsp_data_o);
   endproperty
   a_rsp_hold: assert property (p_rsp_hold) else $error("reply lost");
   property p_sck_half;
      $rose(serial_clock_out_o) |-> serial_clock_out_o[*5] ##1
         !serial_clock_out_o;
   endproperty
   a_sck_half: assert property (p_sck_half) else $error("clock rate");
endmodule
bind sse_top sse_checker chk_i (
   .sys_clk_i, .rstn_i, .mode_o, .rsp_valid_o, .rsp_ready_i, .rsp_data_o,
   .serial_clock_out_o, .serial_select_o, .gp_line_oe_o, .muxbus_oe_o,
   .upper_addr_o, .addr_latch_o, .bus_cs_n_o, .bus_rd_n_o, .bus_wr_n_o,
   .access_ready_in_i
);
`default_nettype wire

// ### sse_defs.vh
// Constants for the serial engine and host bus command interpreter
`ifndef SSE_DEFS_VH
`define SSE_DEFS_VH
`define SSE_MODE_RESET     8'h00
`define SSE_MODE_SERIAL    8'h02
`define SSE_MODE_BUS       8'h08
`define SSE_CMD_SETMODE    8'h80
`define SSE_CMD_SHIFT      8'h10
`define SSE_CMD_SET_LOW    8'h20
`define SSE_CMD_SET_HIGH   8'h21
`define SSE_CMD_GET_LOW    8'h22
`define SSE_CMD_GET_HIGH   8'h23
`define SSE_CMD_WAIT_HI    8'h30
`define SSE_CMD_WAIT_LO    8'h31
`define SSE_CMD_RD         8'h40
`define SSE_CMD_RD_EXT     8'h41
`define SSE_CMD_WR         8'h42
`define SSE_CMD_WR_EXT     8'h43
`define SSE_SYS_CLK_HZ     50000000
`define SSE_MAX_RATE_KBPS  5600
`define SSE_HALF_BIT_CYC   5
`define SSE_FIFO_DEPTH     8
`endif

// ### sse_fifo.v
// Parameterised valid/ready FIFO
`default_nettype none
module sse_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 8,
   parameter AW    = 3
) (
   // Clock and reset
   input  wire             sys_clk_i,
   input  wire             rstn_i,
   // Fill side
   input  wire             in_valid_i,
   output wire             in_ready_o,
   input  wire [WIDTH-1:0] in_data_i,
   // Drain side
   output wire             out_valid_o,
   input  wire             out_ready_i,
   output wire [WIDTH-1:0] out_data_o
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr_ff;
   reg [AW-1:0]    rd_ptr_ff;
   reg [AW:0]      count_ff;
   wire            push;
   wire            pop;
   assign in_ready_o  = (count_ff != DEPTH);
   assign out_valid_o = (count_ff != {(AW+1){1'b0}});
   assign out_data_o  = mem[rd_ptr_ff];
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;
   always @(posedge sys_clk_i) begin
      if (push) begin
         mem[wr_ptr_ff] <= in_data_i;
      end
   end
   always @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wr_ptr_ff <= {AW{1'b0}};
         rd_ptr_ff <= {AW{1'b0}};
         count_ff  <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_ff <= wr_ptr_ff + 1'b1;
         end
         if (pop) begin
            rd_ptr_ff <= rd_ptr_ff + 1'b1;
         end
         if (push & ~pop) begin
            count_ff <= count_ff + 1'b1;
         end else if (pop & ~push) begin
            count_ff <= count_ff - 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// ### sse_periph_model.sv
// Bus peripheral and serial slave seen by the block
`default_nettype none
module sse_periph_model (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rstn_i,
   // Emulated bus side
   input  wire logic [7:0] ad_o_i,
   input  wire logic [7:0] ad_oe_i,
   input  wire logic [7:0] upper_i,
   input  wire logic       ale_i,
   input  wire logic       cs_n_i,
   input  wire logic       rd_n_i,
   input  wire logic       wr_n_i,
   input  wire logic [7:0] stall_i,
   output logic      [7:0] ad_wire_o,
   output logic            ready_o,
   // Serial side
   input  wire logic       sck_i,
   input  wire logic       sdo_i,
   input  wire logic       sel_i,
   input  wire logic [7:0] tx_i,
   output logic            sdi_o,
   output logic      [7:0] rx_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] mem [0:65535];
   logic [7:0] lat, pat, wait_cnt, sh, drv;
   logic       sck_q;
   initial begin
      for (int i = 0; i < 65536; i++) mem[i] = ~i[7:0];
   end
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         lat <= 8'h00;
         pat <= 8'h00;
         wait_cnt <= 8'h00;
      end else begin
         pat <= ~pat;
         if (ale_i) lat <= ad_o_i;
         if (!cs_n_i && !wr_n_i) mem[{upper_i, lat}] <= ad_wire_o;
         if (cs_n_i) wait_cnt <= stall_i;
         else if (wait_cnt != 8'h00) wait_cnt <= wait_cnt - 8'h01;
      end
   end
   // Released lines toggle so a stale value never reads back
   assign drv = (!cs_n_i && !rd_n_i) ? mem[{upper_i, lat}] : pat;
   assign ad_wire_o = (ad_oe_i & ad_o_i) | (~ad_oe_i & drv);
   assign ready_o = cs_n_i || wait_cnt == 8'h00;
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sck_q <= 1'b0;
         sh <= 8'h00;
         rx_o <= 8'h00;
      end else begin
         sck_q <= sck_i;
         if (sel_i) sh <= tx_i;
         else if (!sck_i && sck_q) sh <= {sh[6:0], ~sh[0]};
         if (sck_i && !sck_q) rx_o <= {rx_o[6:0], sdo_i};
      end
   end
   // Input line has a pull-up while deselected
   assign sdi_o = sel_i ? 1'b1 : sh[7];
endmodule
`default_nettype wire

// ### sse_tb.sv
// Self-checking testbench for the command interpreter
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic       sys_clk_i = 0, rstn_i = 0, cmd_valid_i = 0, rsp_ready_i = 0;
   logic       power_enable_n_i = 0, suspend_pull_opt_i = 0;
   logic [7:0] cmd_data_i = 8'h00, gp_drv = 8'h00, stall = 8'h00;
   logic [7:0] tx_byte = 8'hC5;
   wire        cmd_ready_o, rsp_valid_o, busy_o, serial_clock_out_o;
   wire        serial_data_out_o, serial_data_in_i, serial_select_o;
   wire        addr_latch_o, bus_cs_n_o, bus_rd_n_o, bus_wr_n_o;
   wire        access_ready_in_i;
   wire  [7:0] rsp_data_o, mode_o, gp_pull_low_o, muxbus_pull_low_o;
   wire  [7:0] gp_line_i, gp_line_o, gp_line_oe_o, muxbus_i, muxbus_o;
   wire  [7:0] muxbus_oe_o, upper_addr_o, rx_byte;
   int         n_fail = 0, compares = 0;
   time        t0;
   always #10 sys_clk_i = ~sys_clk_i;
   assign gp_line_i = (gp_line_oe_o & gp_line_o) | (~gp_line_oe_o & gp_drv);
   sse_top uut (
      .sys_clk_i, .rstn_i, .cmd_valid_i, .cmd_ready_o, .cmd_data_i,
      .rsp_valid_o, .rsp_ready_i, .rsp_data_o, .mode_o, .busy_o,
      .power_enable_n_i, .suspend_pull_opt_i, .gp_pull_low_o,
      .muxbus_pull_low_o, .serial_clock_out_o, .serial_data_out_o,
      .serial_data_in_i, .serial_select_o, .gp_line_i, .gp_line_o,
      .gp_line_oe_o, .muxbus_i, .muxbus_o, .muxbus_oe_o, .upper_addr_o,
      .addr_latch_o, .bus_cs_n_o, .bus_rd_n_o, .bus_wr_n_o,
      .access_ready_in_i
   );
   sse_periph_model peri (
      .clk_i(sys_clk_i), .rstn_i, .ad_o_i(muxbus_o), .ad_oe_i(muxbus_oe_o),
      .upper_i(upper_addr_o), .ale_i(addr_latch_o), .cs_n_i(bus_cs_n_o),
      .rd_n_i(bus_rd_n_o), .wr_n_i(bus_wr_n_o), .stall_i(stall),
      .ad_wire_o(muxbus_i), .ready_o(access_ready_in_i),
      .sck_i(serial_clock_out_o), .sdo_i(serial_data_out_o),
      .sel_i(serial_select_o), .tx_i(tx_byte), .sdi_o(serial_data_in_i),
      .rx_o(rx_byte)
   );
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // Whole command, bytes back to back, valid held between them
   task automatic cmd(input logic [7:0] q[$]);
      int n;
      foreach (q[i]) begin
         n = 0;
         #1 cmd_valid_i = 1;
         cmd_data_i = q[i];
         // Ready is settled here, so the next edge takes the byte
         while (cmd_ready_o !== 1'b1 && n < 500) begin
            @(posedge sys_clk_i);
            #1 n++;
         end
         if (n >= 500) n_fail++;
         @(posedge sys_clk_i);
      end
      #1 cmd_valid_i = 0;
      @(posedge sys_clk_i);
   endtask
   task automatic rsp(input logic [7:0] exp);
      int n;
      n = 0;
      #1 rsp_ready_i = 1;
      while (rsp_valid_o !== 1'b1 && n < 500) begin
         @(posedge sys_clk_i);
         #1 n++;
      end
      if (n >= 500) n_fail++;
      chk(rsp_data_o, exp);
      // Reply pops at this edge
      @(posedge sys_clk_i);
      #1 rsp_ready_i = 0;
      @(posedge sys_clk_i);
   endtask
   task automatic print_verdict;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      #200us;
      n_fail++;
      print_verdict;
   end
   initial begin
      cyc(2);
      #1 rstn_i = 1;
      @(posedge sys_clk_i);
      chk(mode_o, 8'h00);
      chk({4'h0, bus_cs_n_o, serial_select_o, cmd_ready_o, rsp_valid_o},
         8'h0E);
      cmd('{8'h22});
      cyc(5);
      chk({7'h0, rsp_valid_o}, 8'h00);
      cmd('{8'h80, 8'h02});
      cyc(2);
      chk(mode_o, 8'h02);
      cmd('{8'h20, 8'hA5, 8'h0F});
      cmd('{8'h21, 8'h03, 8'h0D});
      cyc(2);
      chk(gp_line_oe_o, 8'hDF);
      chk(gp_line_o & gp_line_oe_o, 8'h15);
      #1 gp_drv = 8'hFF;
      cyc(2);
      cmd('{8'h23});
      rsp(8'h03);
      cmd('{8'h22});
      rsp(8'h05);
      #1 power_enable_n_i = 1;
      suspend_pull_opt_i = 1;
      cyc(6);
      chk(gp_pull_low_o, 8'h20);
      chk(muxbus_pull_low_o, 8'hFF);
      #1 suspend_pull_opt_i = 0;
      cyc(6);
      chk(gp_pull_low_o, 8'h00);
      chk(muxbus_pull_low_o, 8'h00);
      #1 power_enable_n_i = 0;
      cmd('{8'h10, 8'h3A});
      rsp(8'hC5);
      chk(rx_byte, 8'h3A);
      for (int k = 0; k < 2; k++) begin
         #1 gp_drv = k ? 8'hFF : 8'h00;
         cyc(2);
         cmd('{8'h30 + k[7:0]});
         cyc(20);
         chk({7'h0, busy_o}, 8'h01);
         #1 gp_drv = ~gp_drv;
         cyc(10);
         chk({7'h0, busy_o}, 8'h00);
      end
      cmd('{8'h20, 8'h00, 8'h00});
      for (int i = 0; i < 9; i++) begin
         #1 gp_drv = i[7:0];
         cyc(2);
         cmd('{8'h22});
         cyc(4);
      end
      chk({7'h0, busy_o}, 8'h01);
      for (int i = 0; i < 9; i++) rsp(i[7:0]);
      cmd('{8'h80, 8'h08});
      cyc(2);
      chk(mode_o, 8'h08);
      cmd('{8'h43, 8'h12, 8'h34, 8'h56});
      cyc(30);
      chk(upper_addr_o, 8'h12);
      cmd('{8'h40, 8'h34});
      rsp(8'h56);
      cmd('{8'h42, 8'h35, 8'h99});
      cmd('{8'h41, 8'h12, 8'h35});
      rsp(8'h99);
      cmd('{8'h41, 8'h77, 8'h34});
      rsp(8'hCB);
      chk(upper_addr_o, 8'h77);
      #1 stall = 8'd40;
      t0 = $time;
      cmd('{8'h40, 8'h34});
      rsp(8'hCB);
      chk({7'h0, ($time - t0) > 800}, 8'h01);
      #1 stall = 8'h00;
      cmd('{8'h80, 8'h00});
      cyc(2);
      chk(mode_o, 8'h00);
      chk(upper_addr_o, 8'h00);
      print_verdict;
   end
endmodule
`default_nettype wire

// ### sse_top.v
// Command interpreter for serial engine and host bus emulation
`include "sse_defs.vh"
`default_nettype none
module sse_top (
   // Clock and reset
   input  wire        sys_clk_i,
   input  wire        rstn_i,
   // Command stream in
   input  wire        cmd_valid_i,
   output wire        cmd_ready_o,
   input  wire [7:0]  cmd_data_i,
   // Read-back stream out
   output wire        rsp_valid_o,
   input  wire        rsp_ready_i,
   output wire [7:0]  rsp_data_o,
   // Status
   output wire [7:0]  mode_o,
   output wire        busy_o,
   // Suspend control
   input  wire        power_enable_n_i,
   input  wire        suspend_pull_opt_i,
   output wire [7:0]  gp_pull_low_o,
   output wire [7:0]  muxbus_pull_low_o,
   // Serial engine pins
   output wire        serial_clock_out_o,
   output wire        serial_data_out_o,
   input  wire        serial_data_in_i,
   output wire        serial_select_o,
   // General-purpose lines, low nibble then high
   input  wire [7:0]  gp_line_i,
   output wire [7:0]  gp_line_o,
   output wire [7:0]  gp_line_oe_o,
   // Emulated host bus
   input  wire [7:0]  muxbus_i,
   output wire [7:0]  muxbus_o,
   output wire [7:0]  muxbus_oe_o,
   output wire [7:0]  upper_addr_o,
   output wire        addr_latch_o,
   output wire        bus_cs_n_o,
   output wire        bus_rd_n_o,
   output wire        bus_wr_n_o,
   input  wire        access_ready_in_i
);
   localparam ST_IDLE  = 4'h0;
   localparam ST_ARG1  = 4'h1;
   localparam ST_ARG2  = 4'h2;
   localparam ST_ARG3  = 4'h3;
   localparam ST_SHIFT = 4'h4;
   localparam ST_WAIT  = 4'h5;
   localparam ST_ALE   = 4'h6;
   localparam ST_ACC   = 4'h7;
   localparam ST_RESP  = 4'h8;
   localparam ST_HOLD  = 4'h9;
   // Input synchronisers
   reg [19:0] sync1_ff;
   reg [19:0] sync2_ff;
   wire       sdi_s   = sync2_ff[0];
   wire       rdy_s   = sync2_ff[1];
   wire       pwr_s   = sync2_ff[2];
   wire [7:0] gp_s    = sync2_ff[10:3];
   wire       opt_s   = sync2_ff[11];
   wire [7:0] mb_s    = sync2_ff[19:12];
   reg [3:0]  state_ff;
   reg [7:0]  mode_ff;
   reg [7:0]  op_ff;
   reg [7:0]  a1_ff;
   reg [7:0]  a2_ff;
   reg [7:0]  gp_out_ff;
   reg [7:0]  gp_dir_ff;
   reg        sck_ff;
   reg        sdo_ff;
   reg        sel_ff;
   reg [7:0]  shr_ff;
   reg [2:0]  bitcnt_ff;
   reg [2:0]  div_ff;
   reg [7:0]  upper_ff;
   reg [7:0]  mb_out_ff;
   reg        mb_oe_ff;
   reg        ale_ff;
   reg        cs_n_ff;
   reg        rd_n_ff;
   reg        wr_n_ff;
   reg [7:0]  rsp_ff;
   reg        rsp_v_ff;
   wire       fifo_ready;
   wire       take = cmd_valid_i & cmd_ready_o;
   wire       serial_on = (mode_ff == `SSE_MODE_SERIAL);
   wire       bus_on = (mode_ff == `SSE_MODE_BUS);
   // Number of argument bytes that follow an opcode
   function [1:0] arg_count;
      input [7:0] op;
      begin
         case (op)
            `SSE_CMD_SETMODE:  arg_count = 2'd1;
            `SSE_CMD_SHIFT:    arg_count = 2'd1;
            `SSE_CMD_SET_LOW:  arg_count = 2'd2;
            `SSE_CMD_SET_HIGH: arg_count = 2'd2;
            `SSE_CMD_RD:       arg_count = 2'd1;
            `SSE_CMD_RD_EXT:   arg_count = 2'd2;
            `SSE_CMD_WR:       arg_count = 2'd2;
            `SSE_CMD_WR_EXT:   arg_count = 2'd3;
            default:           arg_count = 2'd0;
         endcase
      end
   endfunction
   // Opcode legal for the current mode
   function op_allowed;
      input [7:0] op;
      input       ser;
      input       bus;
      begin
         case (op)
            `SSE_CMD_SETMODE: op_allowed = 1'b1;
            `SSE_CMD_SHIFT, `SSE_CMD_SET_LOW, `SSE_CMD_SET_HIGH,
            `SSE_CMD_GET_LOW, `SSE_CMD_GET_HIGH: op_allowed = ser;
            `SSE_CMD_WAIT_HI, `SSE_CMD_WAIT_LO: op_allowed = ser | bus;
            `SSE_CMD_RD, `SSE_CMD_RD_EXT, `SSE_CMD_WR,
            `SSE_CMD_WR_EXT: op_allowed = bus;
            default: op_allowed = 1'b0;
         endcase
      end
   endfunction
   assign cmd_ready_o = (state_ff == ST_IDLE) ? ~rsp_v_ff :
                        (state_ff <= ST_ARG3);
   assign busy_o = ~((state_ff == ST_IDLE) & ~rsp_v_ff);
   assign mode_o = mode_ff;
   always @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sync1_ff <= 20'h00000;
         sync2_ff <= 20'h00000;
      end else begin
         sync1_ff <= {muxbus_i, suspend_pull_opt_i, gp_line_i,
                      power_enable_n_i, access_ready_in_i, serial_data_in_i};
         sync2_ff <= sync1_ff;
      end
   end
   always @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_ff  <= ST_IDLE;
         mode_ff   <= `SSE_MODE_RESET;
         op_ff     <= 8'h00;
         a1_ff     <= 8'h00;
         a2_ff     <= 8'h00;
         gp_out_ff <= 8'h00;
         gp_dir_ff <= 8'h00;
         sck_ff    <= 1'b0;
         sdo_ff    <= 1'b0;
         sel_ff    <= 1'b1;
         shr_ff    <= 8'h00;
         bitcnt_ff <= 3'd0;
         div_ff    <= 3'd0;
         upper_ff  <= 8'h00;
         mb_out_ff <= 8'h00;
         mb_oe_ff  <= 1'b0;
         ale_ff    <= 1'b0;
         cs_n_ff   <= 1'b1;
         rd_n_ff   <= 1'b1;
         wr_n_ff   <= 1'b1;
         rsp_ff    <= 8'h00;
         rsp_v_ff  <= 1'b0;
      end else begin
         if (rsp_v_ff & fifo_ready) begin
            rsp_v_ff <= 1'b0;
         end
         case (state_ff)
            ST_IDLE: begin
               if (take) begin
                  op_ff <= cmd_data_i;
                  if (!op_allowed(cmd_data_i, serial_on, bus_on)) begin
                     state_ff <= ST_IDLE;
                  end else if (arg_count(cmd_data_i) != 2'd0) begin
                     state_ff <= ST_ARG1;
                  end else if (cmd_data_i == `SSE_CMD_GET_LOW) begin
                     rsp_ff   <= {4'h0, gp_s[3:0]};
                     state_ff <= ST_RESP;
                  end else if (cmd_data_i == `SSE_CMD_GET_HIGH) begin
                     rsp_ff   <= {4'h0, gp_s[7:4]};
                     state_ff <= ST_RESP;
                  end else begin
                     state_ff <= ST_WAIT;
                  end
               end
            end
            ST_ARG1: begin
               if (take) begin
                  a1_ff <= cmd_data_i;
                  if (op_ff == `SSE_CMD_SETMODE) begin
                     // Any value but 02 or 08 idles everything; bytes already in the read-back FIFO stay queued
                     mode_ff   <= (cmd_data_i == `SSE_MODE_SERIAL ||
                                   cmd_data_i == `SSE_MODE_BUS) ?
                                  cmd_data_i : `SSE_MODE_RESET;
                     gp_dir_ff <= 8'h00;
                     gp_out_ff <= 8'h00;
                     sel_ff    <= 1'b1;
                     sck_ff    <= 1'b0;
                     sdo_ff    <= 1'b0;
                     mb_oe_ff  <= 1'b0;
                     upper_ff  <= 8'h00;
                     rsp_v_ff  <= 1'b0;
                     state_ff  <= ST_IDLE;
                  end else if (op_ff == `SSE_CMD_SHIFT) begin
                     shr_ff    <= cmd_data_i;
                     sdo_ff    <= cmd_data_i[7];
                     sel_ff    <= 1'b0;
                     bitcnt_ff <= 3'd0;
                     div_ff    <= 3'd0;
                     state_ff  <= ST_SHIFT;
                  end else if (op_ff == `SSE_CMD_RD) begin
                     state_ff <= ST_ALE;
                  end else begin
                     state_ff <= ST_ARG2;
                  end
               end
            end
            ST_ARG2: begin
               if (take) begin
                  a2_ff <= cmd_data_i;
                  if (op_ff == `SSE_CMD_SET_LOW) begin
                     gp_out_ff[3:0] <= a1_ff[3:0];
                     gp_dir_ff[3:0] <= cmd_data_i[3:0];
                     state_ff <= ST_IDLE;
                  end else if (op_ff == `SSE_CMD_SET_HIGH) begin
                     gp_out_ff[7:4] <= a1_ff[3:0];
                     gp_dir_ff[7:4] <= cmd_data_i[3:0];
                     state_ff <= ST_IDLE;
                  end else if (op_ff == `SSE_CMD_RD_EXT) begin
                     upper_ff <= a1_ff;
                     a1_ff    <= cmd_data_i;
                     state_ff <= ST_ALE;
                  end else if (op_ff == `SSE_CMD_WR) begin
                     state_ff <= ST_ALE;
                  end else begin
                     state_ff <= ST_ARG3;
                  end
               end
            end
            ST_ARG3: begin
               if (take) begin
                  upper_ff <= a1_ff;
                  a1_ff    <= a2_ff;
                  a2_ff    <= cmd_data_i;
                  state_ff <= ST_ALE;
               end
            end
            ST_SHIFT: begin
               // MSB first, data in sampled on rising clock edge
               if (div_ff == `SSE_HALF_BIT_CYC - 1) begin
                  div_ff <= 3'd0;
                  sck_ff <= ~sck_ff;
                  if (!sck_ff) begin
                     shr_ff <= {shr_ff[6:0], sdi_s};
                  end else if (bitcnt_ff == 3'd7) begin
                     sel_ff   <= 1'b1;
                     rsp_ff   <= shr_ff;
                     state_ff <= ST_RESP;
                  end else begin
                     bitcnt_ff <= bitcnt_ff + 3'd1;
                     sdo_ff    <= shr_ff[7];
                  end
               end else begin
                  div_ff <= div_ff + 3'd1;
               end
            end
            ST_WAIT: begin
               if (gp_s[5] == (op_ff == `SSE_CMD_WAIT_HI)) begin
                  state_ff <= ST_IDLE;
               end
            end
            ST_ALE: begin
               // Address phase: bus driven, latch pulse high
               mb_out_ff <= a1_ff;
               mb_oe_ff  <= 1'b1;
               ale_ff    <= ~ale_ff;
               if (ale_ff) begin
                  cs_n_ff <= 1'b0;
                  if (op_ff[1]) begin
                     mb_out_ff <= a2_ff;
                     wr_n_ff   <= 1'b0;
                  end else begin
                     mb_oe_ff <= 1'b0;
                     rd_n_ff  <= 1'b0;
                  end
                  div_ff   <= 3'd0;
                  state_ff <= ST_ACC;
               end
            end
            ST_ACC: begin
               if (div_ff != `SSE_HALF_BIT_CYC - 1) begin
                  div_ff <= div_ff + 3'd1;
               end else if (rdy_s) begin
                  cs_n_ff <= 1'b1;
                  rd_n_ff <= 1'b1;
                  wr_n_ff <= 1'b1;
                  if (!op_ff[1]) begin
                     rsp_ff   <= mb_s;
                     state_ff <= ST_RESP;
                  end else begin
                     state_ff <= ST_HOLD;
                  end
               end
            end
            ST_RESP: begin
               rsp_v_ff <= 1'b1;
               state_ff <= ST_IDLE;
            end
            ST_HOLD: begin
               mb_oe_ff <= 1'b0;
               state_ff <= ST_IDLE;
            end
            default: state_ff <= ST_IDLE;
         endcase
      end
   end
   // Read-back buffer; back-pressure stalls the interpreter
   sse_fifo #(
      .WIDTH (8),
      .DEPTH (`SSE_FIFO_DEPTH),
      .AW    (3)
   ) u_rsp_fifo (
      .sys_clk_i   (sys_clk_i),
      .rstn_i      (rstn_i),
      .in_valid_i  (rsp_v_ff),
      .in_ready_o  (fifo_ready),
      .in_data_i   (rsp_ff),
      .out_valid_o (rsp_valid_o),
      .out_ready_i (rsp_ready_i),
      .out_data_o  (rsp_data_o)
   );
   // Only the first channel's pins carry the serial engine
   assign serial_clock_out_o = serial_on & sck_ff;
   assign serial_data_out_o  = serial_on & sdo_ff;
   assign serial_select_o    = ~serial_on | sel_ff;
   assign gp_line_o          = gp_out_ff;
   assign gp_line_oe_o       = serial_on ? gp_dir_ff : 8'h00;
   assign gp_pull_low_o      = (opt_s & pwr_s) ?
                               ~gp_line_oe_o : 8'h00;
   // Both channels form one bus in bus mode
   assign muxbus_o           = mb_out_ff;
   assign muxbus_oe_o        = (bus_on & mb_oe_ff) ? 8'hFF : 8'h00;
   assign muxbus_pull_low_o  = (opt_s & pwr_s) ?
                               ~muxbus_oe_o : 8'h00;
   assign upper_addr_o       = bus_on ? upper_ff : 8'h00;
   assign addr_latch_o       = bus_on & ale_ff;
   assign bus_cs_n_o         = ~bus_on | cs_n_ff;
   assign bus_rd_n_o         = ~bus_on | rd_n_ff;
   assign bus_wr_n_o         = ~bus_on | wr_n_ff;
endmodule
`default_nettype wire
